// >>> dv/ext_pin_model.sv
module ext_pin_model #(
  parameter int PIN_W = 32
) (
  // From the port
  input  wire logic [PIN_W-1:0] pin_out_in,
  input  wire logic [PIN_W-1:0] pin_oe_n_in,
  input  wire logic [PIN_W-1:0] pin_pulldown_in,
  // Source controls
  input  wire logic [PIN_W-1:0] src_value_in,
  input  wire logic             src_drive_in,
  input  wire logic             src_ready_in,
  // To the port
  output logic      [PIN_W-1:0] pin_level_out,
  output logic                  qualify_strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board pull-ups, so a released pin never keeps a stale value
  assign pin_level_out = (~pin_oe_n_in & pin_out_in) |
                         (pin_oe_n_in & (src_drive_in ? src_value_in : ~pin_pulldown_in));
  // Strobe only ever rides on presented data
  assign qualify_strobe_out = src_drive_in & src_ready_in;
endmodule : ext_pin_model

// >>> dv/test_timed_serdes_io_port.sv
module test_timed_serdes_io_port;
  timeunit 1ns;
  timeprecision 1ps;
  import serdes_io_pkg::*;
  logic clk, rst, en, omode, oc, sen, cpin, wv, tmd, ack, rv, busy, qs, qso, sdrv, srdy;
  port_width_t wsel;
  cond_mode_t cmode;
  logic [2:0] csel;
  logic [5:0] cfp;
  logic [7:0] cdiv, crate;
  logic [15:0] tval, ts, cnt, c0;
  logic [31:0] lclm, nclm, cval, wd, rd, pout, poe, ppd, plev, sval;
  int mismatches, checks_done;
  port_width_t wt [5] = '{WIDTH_1, WIDTH_4, WIDTH_8, WIDTH_16, WIDTH_32};
  logic [31:0] wm [5] = '{32'h0000_0001, 32'h0000_000f, 32'h0000_00ff, 32'h0000_ffff, 32'hffff_ffff};
  timed_serdes_io_port uut (.core_clk_in(clk), .reset_in(rst), .width_sel_in(wsel), .port_enable_in(en),
    .output_mode_in(omode), .open_collector_in(oc), .strobe_enable_in(sen), .link_claim_in(lclm),
    .narrow_claim_in(nclm), .cond_mode_in(cmode), .cond_value_in(cval), .clkb_sel_in(csel),
    .clkb_from_pin_in(cfp), .clkb_div_in(cdiv), .clkb_rate_in(crate), .clk_pin_in(cpin), .wr_valid_in(wv),
    .wr_data_in(wd), .timed_in(tmd), .timed_value_in(tval), .rd_ack_in(ack), .rd_valid_out(rv),
    .rd_data_out(rd), .timestamp_out(ts), .counter_out(cnt), .busy_out(busy), .pin_in(plev),
    .pin_out(pout), .pin_oe_n_out(poe), .pin_pulldown_out(ppd), .input_qualify_strobe_in(qs),
    .output_qualify_strobe_out(qso));
  ext_pin_model model (.pin_out_in(pout), .pin_oe_n_in(poe), .pin_pulldown_in(ppd), .src_value_in(sval),
    .src_drive_in(sdrv), .src_ready_in(srdy), .pin_level_out(plev), .qualify_strobe_out(qs));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Counts strobe pulses until the port is idle again
  task automatic wr(input logic [31:0] d, input logic t, input logic [15:0] v, output int p);
    wd = d;
    tmd = t;
    tval = v;
    wv = 1'b1;
    cyc(1);
    wv = 1'b0;
    tmd = 1'b0;
    chk("busy", 32'h1, {31'h0, busy});
    p = 0;
    for (int i = 0; i < 300 && (busy !== 1'b0 || i < 3); i++) begin
      cyc(1);
      if (qso === 1'b1) p++;
    end
  endtask : wr
  task automatic t_counter;
    c0 = cnt;
    cyc(5);
    chk("counter", 32'h5, 32'(cnt - c0));
    csel = 3'h1;
    crate = 8'h03;
    cyc(8);
    c0 = cnt;
    cyc(8);
    chk("counter_rate", 32'h2, 32'(cnt - c0));
    csel = 3'h2;
    cfp = 6'h04;
    cdiv = 8'h01;
    cyc(8);
    c0 = cnt;
    repeat (4) begin
      cpin = 1'b1;
      cyc(3);
      cpin = 1'b0;
      cyc(3);
    end
    cyc(6);
    chk("counter_pin", 32'h2, 32'(cnt - c0));
    csel = 3'h0;
    en = 1'b0;
    c0 = cnt;
    cyc(4);
    chk("counter_off", 32'h0, 32'(cnt - c0));
    chk("off_oe_n", 32'hffff_ffff, poe);
    en = 1'b1;
  endtask : t_counter
  task automatic t_output;
    int p;
    for (int i = 0; i < 5; i++) begin
      wsel = wt[i];
      wr(32'hc3a5_5a3c, 1'b0, 16'h0000, p);
      chk("pin_out", 32'hc3a5_5a3c & wm[i], pout & wm[i]);
      chk("pin_oe_n", ~wm[i], poe);
      chk("strobes", 32'h1, p);
    end
    wsel = WIDTH_8;
    nclm = 32'h0000_00f0;
    lclm = 32'h0000_0003;
    wr(32'h0000_00ff, 1'b0, 16'h0000, p);
    chk("shared_oe_n", 32'hffff_fff3, poe);
    nclm = 32'h0;
    lclm = 32'h0;
    oc = 1'b1;
    wr(32'h0000_00a5, 1'b0, 16'h0000, p);
    chk("oc_oe_n", 32'hffff_ffa5, poe);
    chk("oc_level", 32'h0000_00a5, plev & 32'h0000_00ff);
    oc = 1'b0;
    tval = cnt + 16'h0014;
    wr(32'h0000_003c, 1'b1, tval, p);
    chk("timestamp", {16'h0, tval}, {16'h0, ts});
    chk("timed_strobe", 32'h1, p);
  endtask : t_output
  // Waits for a word; x set means one must arrive
  task automatic rx(input string nm, input logic x, input logic [31:0] e);
    for (int i = 0; i < 30 && rv !== 1'b1; i++) cyc(1);
    chk(nm, {31'h0, x}, {31'h0, rv});
    if (x) chk(nm, e, rd);
  endtask : rx
  task automatic t_input;
    omode = 1'b0;
    wsel = WIDTH_16;
    sval = 32'h1234_beef;
    sdrv = 1'b1;
    rx("unqualified", 1'b0, 32'h0);
    chk("in_oe_n", 32'hffff_ffff, poe);
    srdy = 1'b1;
    rx("qualified", 1'b1, 32'h0000_beef);
    srdy = 1'b0;
    wsel = WIDTH_8;
    cmode = COND_EQ;
    cval = 32'h0000_005a;
    sval = 32'h0000_0033;
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    sen = 1'b0;
    rx("cond_hold", 1'b0, 32'h0);
    sval = 32'h0000_005a;
    rx("cond_eq", 1'b1, 32'h0000_005a);
    cmode = COND_NEQ;
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    rx("cond_neq_hold", 1'b0, 32'h0);
    sval = 32'h0000_0011;
    rx("cond_neq", 1'b1, 32'h0000_0011);
  endtask : t_input
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  initial begin
    rst = 1'b1;
    en = 1'b1;
    omode = 1'b1;
    sen = 1'b1;
    {oc, cpin, wv, tmd, ack, sdrv, srdy} = 7'h00;
    csel = 3'h0;
    cfp = 6'h00;
    cdiv = 8'h00;
    crate = 8'h00;
    wsel = WIDTH_1;
    cmode = COND_NONE;
    {lclm, nclm, cval, wd, sval} = 160'h0;
    tval = 16'h0000;
    mismatches = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    #1;
    chk("reset_pulldown", 32'hffff_ffff, ppd);
    chk("reset_oe_n", 32'hffff_ffff, poe);
    chk("reset_count", 32'h0, {16'h0, cnt});
    rst = 1'b0;
    cyc(2);
    chk("pulldown_off", 32'h0, ppd);
    t_counter();
    t_output();
    t_input();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule : test_timed_serdes_io_port

// >>> include/serdes_io_pkg.sv
package serdes_io_pkg;
  localparam int          NUM_CLK_BLOCKS = 6;
  localparam int          CLKB_SEL_W     = 3;
  localparam logic [2:0]  CLKB_RESET_SEL = 3'h0;
  localparam int          COUNT_W        = 16;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam int          DIV_W          = 8;
  localparam int          REF_CLK_MHZ    = 100;
  localparam int          CORE_CLK_MHZ   = 25;
  localparam int          REF_TICK_CYC   = (CORE_CLK_MHZ >= REF_CLK_MHZ) ? CORE_CLK_MHZ / REF_CLK_MHZ : 1;
  localparam int          NUM_WIDTHS     = 5;
  typedef enum logic [4:0] {
    WIDTH_1  = 5'h01,
    WIDTH_4  = 5'h02,
    WIDTH_8  = 5'h04,
    WIDTH_16 = 5'h08,
    WIDTH_32 = 5'h10
  } port_width_t;
  typedef enum logic [1:0] {
    COND_NONE = 2'h0,
    COND_EQ   = 2'h1,
    COND_NEQ  = 2'h2
  } cond_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_WAIT    = 3'h2,
    ST_DONE    = 3'h4
  } xfer_state_t;
endpackage : serdes_io_pkg

// >>> verilog/timed_serdes_io_port.sv
// Notes on behaviour
// - Port width selectable as 1, 4, 8, 16 or 32 pins.
// - All pins of the port share one direction.
// - Drive pins high or low; sample, optionally holding until a pin condition.
// - Every processor access completes in one cycle.
// - Open-collector: zero pulls low, one leaves pin undriven.
// - Data passes through a shift register and a transfer register.
// - A 16-bit port counter schedules pin/transfer-register moves.
// - Counter readable any time; transfers may wait for a set counter value.
// - Each transfer captures the counter as a timestamp.
// - An enabled link disables the port on shared pins.
// - An enabled narrower port overrides this port on shared pins.
// - Pins not claimed by a narrower port stay with this port.
// - Transfers are always at the declared width.
// - Six clock blocks; block 0 is the reference clock at 100 MHz (here block 0 ticks once per 25 MHz core clock cycle).
// - Blocks 1 to 5 run at programmable other rates.
// - A clock block may take its clock from a one-pin port.
// - A pin-sourced clock may be divided first.
// - Input transfers are qualified by the external ready strobe.
// - Output transfers are accompanied by a generated ready strobe.
// - After reset the port uses clock block 0 (here the block always follows clkb_sel_in; reset does not select it).
// - While in reset all pins have pull-downs enabled.
module timed_serdes_io_port
  import serdes_io_pkg::*;
#(
  parameter int PIN_W = 32
) (
  // Clock and reset
  input  wire logic                               core_clk_in,
  input  wire logic                               reset_in,
  // Configuration
  input  wire serdes_io_pkg::port_width_t         width_sel_in,
  input  wire logic                               port_enable_in,
  input  wire logic                               output_mode_in,
  input  wire logic                               open_collector_in,
  input  wire logic                               strobe_enable_in,
  input  wire logic [PIN_W-1:0]                   link_claim_in,
  input  wire logic [PIN_W-1:0]                   narrow_claim_in,
  input  wire serdes_io_pkg::cond_mode_t          cond_mode_in,
  input  wire logic [PIN_W-1:0]                   cond_value_in,
  // Clock blocks
  input  wire logic [serdes_io_pkg::CLKB_SEL_W-1:0] clkb_sel_in,
  input  wire logic [serdes_io_pkg::NUM_CLK_BLOCKS-1:0] clkb_from_pin_in,
  input  wire logic [serdes_io_pkg::DIV_W-1:0]    clkb_div_in,
  input  wire logic [serdes_io_pkg::DIV_W-1:0]    clkb_rate_in,
  input  wire logic                               clk_pin_in,
  // Processor side
  input  wire logic                               wr_valid_in,
  input  wire logic [31:0]                        wr_data_in,
  input  wire logic                               timed_in,
  input  wire logic [serdes_io_pkg::COUNT_W-1:0]  timed_value_in,
  input  wire logic                               rd_ack_in,
  output logic                                    rd_valid_out,
  output logic [31:0]                             rd_data_out,
  output logic [serdes_io_pkg::COUNT_W-1:0]       timestamp_out,
  output logic [serdes_io_pkg::COUNT_W-1:0]       counter_out,
  output logic                                    busy_out,
  // Pins
  input  wire logic [PIN_W-1:0]                   pin_in,
  output logic [PIN_W-1:0]                        pin_out,
  output logic [PIN_W-1:0]                        pin_oe_n_out,
  output logic [PIN_W-1:0]                        pin_pulldown_out,
  input  wire logic                               input_qualify_strobe_in,
  output logic                                    output_qualify_strobe_out
);
  import serdes_io_pkg::*;

  // Pins cross in from outside: two flops each
  logic [PIN_W-1:0] pin_meta_q, pin_sync_q;
  logic [2:0]       aux_meta_q, aux_sync_q, aux_prev_q;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      aux_meta_q <= 3'h0;
      aux_sync_q <= 3'h0;
      aux_prev_q <= 3'h0;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
      aux_meta_q <= {input_qualify_strobe_in, clk_pin_in, 1'b0};
      aux_sync_q <= aux_meta_q;
      aux_prev_q <= aux_sync_q;
    end
  end
  wire ext_strobe = aux_sync_q[2];
  wire pin_clk_rise = aux_sync_q[1] & ~aux_prev_q[1];

  // Width mask, one-hot decode
  logic [31:0] width_mask;
  always_comb begin
    case (width_sel_in)
      WIDTH_1:  width_mask = 32'h0000_0001;
      WIDTH_4:  width_mask = 32'h0000_000f;
      WIDTH_8:  width_mask = 32'h0000_00ff;
      WIDTH_16: width_mask = 32'h0000_ffff;
      WIDTH_32: width_mask = 32'hffff_ffff;
      default:  width_mask = 32'h0000_0001;
    endcase
  end
  wire [PIN_W-1:0] mask = width_mask[PIN_W-1:0];

  // Clock block 0 ticks every core clock cycle; others divide core clock or pin clock
  logic [DIV_W-1:0] div_cnt_q;
  logic [DIV_W-1:0] div_cnt_d;
  wire              from_pin   = (clkb_sel_in != CLKB_RESET_SEL) && (clkb_sel_in < 3'(NUM_CLK_BLOCKS))
                                 && clkb_from_pin_in[clkb_sel_in];
  wire              src_edge   = from_pin ? pin_clk_rise : 1'b1;
  wire [DIV_W-1:0]  div_limit  = from_pin ? clkb_div_in : clkb_rate_in;
  wire              div_wrap   = (div_cnt_q >= div_limit);
  wire              tick       = (clkb_sel_in == CLKB_RESET_SEL) ? 1'b1 : (src_edge & div_wrap);
  assign div_cnt_d = !src_edge ? div_cnt_q : (div_wrap ? '0 : div_cnt_q + 1'b1);

  // Port counter
  logic [COUNT_W-1:0] count_q;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_q   <= COUNT_RESET;
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_d;
      if (tick && port_enable_in) count_q <= count_q + 1'b1;
    end
  end
  assign counter_out = count_q;

  // Pin ownership: link and narrower ports win, rest stays ours
  wire [PIN_W-1:0] owned = mask & ~link_claim_in & ~narrow_claim_in & {PIN_W{port_enable_in}};

  // Transfer sequencing
  xfer_state_t      state_q, state_d;
  logic [PIN_W-1:0] shift_q, xfer_q, drive_q;
  logic             xfer_full_q, strobe_q;
  logic [COUNT_W-1:0] ts_q, due_q;
  logic             timed_q;

  wire [PIN_W-1:0] sample   = pin_sync_q & mask;
  wire cond_met = (cond_mode_in == COND_NONE) ? 1'b1 :
                  (cond_mode_in == COND_EQ) ? (sample == (cond_value_in & mask)) :
                  (sample != (cond_value_in & mask));
  wire time_ok  = !timed_q || (count_q == due_q);
  wire qual_ok  = !strobe_enable_in || ext_strobe;
  wire in_fire  = !output_mode_in && tick && time_ok && cond_met && qual_ok && !xfer_full_q;
  wire out_fire = output_mode_in && tick && time_ok && xfer_full_q;
  wire fire     = (state_q == ST_WAIT) && (in_fire || out_fire);
  wire accept   = wr_valid_in && (state_q == ST_IDLE);

  always_comb begin
    case (state_q)
      ST_IDLE: state_d = (accept || (!output_mode_in && port_enable_in && !xfer_full_q)) ? ST_WAIT : ST_IDLE;
      ST_WAIT: state_d = fire ? ST_DONE : ST_WAIT;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q     <= ST_IDLE;
      shift_q     <= '0;
      xfer_q      <= '0;
      drive_q     <= '0;
      xfer_full_q <= 1'b0;
      strobe_q    <= 1'b0;
      ts_q        <= COUNT_RESET;
      due_q       <= COUNT_RESET;
      timed_q     <= 1'b0;
    end else begin
      state_q  <= state_d;
      strobe_q <= fire && output_mode_in && strobe_enable_in;
      if (accept) begin
        xfer_q      <= wr_data_in[PIN_W-1:0] & mask;
        xfer_full_q <= 1'b1;
        timed_q     <= timed_in;
        due_q       <= timed_value_in;
      end else if (state_q == ST_IDLE && !output_mode_in && !xfer_full_q) begin
        timed_q <= timed_in;
        due_q   <= timed_value_in;
      end
      if (fire) begin
        ts_q    <= count_q;
        timed_q <= 1'b0;
        if (output_mode_in) begin
          shift_q     <= xfer_q & mask;
          drive_q     <= xfer_q & mask;
          xfer_full_q <= 1'b0;
        end else begin
          shift_q     <= sample;
          xfer_q      <= sample;
          xfer_full_q <= 1'b1;
        end
      end else if (rd_ack_in && rd_valid_out && !accept) begin // New word wins over a same-cycle ack
        xfer_full_q <= 1'b0;
      end
    end
  end

  assign rd_valid_out  = !output_mode_in && xfer_full_q && (state_q != ST_WAIT);
  assign rd_data_out   = 32'(xfer_q);
  assign timestamp_out = ts_q;
  assign busy_out      = (state_q != ST_IDLE);
  assign output_qualify_strobe_out = strobe_q;

  // One direction for all owned pins; open collector releases ones
  genvar i;
  generate
    for (i = 0; i < PIN_W; i++) begin : g_pin
      wire drive_en = owned[i] && output_mode_in && !reset_in;
      assign pin_out[i]          = open_collector_in ? 1'b0 : drive_q[i];
      assign pin_oe_n_out[i]     = !(drive_en && (!open_collector_in || !drive_q[i]));
      assign pin_pulldown_out[i] = reset_in;
    end
  endgenerate

  a_count_wraps: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (tick && port_enable_in && count_q == 16'hffff) |=> (count_q == 16'h0000))
    else $error("Counter did not wrap");
  a_count_holds: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (!port_enable_in) |=> $stable(count_q))
    else $error("Counter moved while disabled");
  a_stamp_taken: assert property (@(posedge core_clk_in) disable iff (reset_in)
    fire |=> (timestamp_out == $past(count_q)))
    else $error("Timestamp not captured");
  a_timed_wait: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (fire && timed_q) |-> (count_q == due_q))
    else $error("Timed transfer fired early");
  a_qualify_in: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (fire && !output_mode_in && strobe_enable_in) |-> ext_strobe)
    else $error("Input taken without strobe");
  a_strobe_out: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (fire && output_mode_in && strobe_enable_in) |=> output_qualify_strobe_out)
    else $error("Output strobe missing");
  a_link_wins: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ((link_claim_in | narrow_claim_in) & ~pin_oe_n_out) == '0)
    else $error("Claimed pin driven");
  a_oc_release: assert property (@(posedge core_clk_in) disable iff (reset_in)
    open_collector_in |-> ((drive_q & ~pin_oe_n_out) == '0))
    else $error("Open collector drove high");
  a_input_quiet: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !output_mode_in |-> (pin_oe_n_out == '1))
    else $error("Input port drove pins");
  a_width_kept: assert property (@(posedge core_clk_in) disable iff (reset_in)
    fire |=> ((shift_q & ~$past(mask)) == '0))
    else $error("Data wider than port");

  // Reset and pin drive
  a_reset_pulls: assert property (@(posedge core_clk_in)
    reset_in |-> (pin_pulldown_out == '1 && pin_oe_n_out == '1))
    else $error("Pins not pulled down in reset");
  a_pulls_off: assert property (@(posedge core_clk_in)
    !reset_in |-> (pin_pulldown_out == '0))
    else $error("Pull-down left on after reset");
  a_oc_low: assert property (@(posedge core_clk_in) disable iff (reset_in)
    open_collector_in |-> (pin_out == '0))
    else $error("Open collector value not low");
  a_drive_owned: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (output_mode_in && !open_collector_in) |-> (pin_oe_n_out == ~owned))
    else $error("Owned pins not driven");
  a_disabled_quiet: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !port_enable_in |-> (pin_oe_n_out == '1))
    else $error("Disabled port drove pins");
  a_out_drive: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (fire && output_mode_in) |=> (drive_q == ($past(xfer_q) & $past(mask))))
    else $error("Output word not driven");
  a_strobe_pulse: assert property (@(posedge core_clk_in) disable iff (reset_in)
    output_qualify_strobe_out |=> !output_qualify_strobe_out)
    else $error("Output strobe longer than one cycle");

  // Clocking and counter
  a_block0_tick: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clkb_sel_in == CLKB_RESET_SEL && port_enable_in) |=> (count_q == $past(count_q) + 16'h0001))
    else $error("Block 0 did not tick every cycle");
  a_rate_tick: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clkb_sel_in != CLKB_RESET_SEL && !from_pin && div_cnt_q < div_limit) |-> !tick)
    else $error("Rate block ticked early");
  a_pin_divided: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (from_pin && !pin_clk_rise) |-> !tick)
    else $error("Pin clock ticked without an edge");
  a_ts_still: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !fire |=> $stable(timestamp_out))
    else $error("Timestamp moved without a transfer");

  // Transfer handshake
  a_one_cycle: assert property (@(posedge core_clk_in) disable iff (reset_in)
    accept |=> (state_q == ST_WAIT))
    else $error("Write not taken in one cycle");
  a_done_once: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == ST_DONE) |=> (state_q == ST_IDLE))
    else $error("Done state held");
  a_input_arms: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == ST_IDLE && !output_mode_in && port_enable_in && !xfer_full_q) |=> (state_q == ST_WAIT))
    else $error("Input did not arm");
  a_in_sample: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (fire && !output_mode_in) |=> (xfer_q == $past(sample)))
    else $error("Input sample not stored");
  a_in_width: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (fire && !output_mode_in) |=> ((xfer_q & ~$past(mask)) == '0))
    else $error("Input word wider than port");
  a_ack_clears: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (rd_ack_in && rd_valid_out && !accept) |=> !rd_valid_out)
    else $error("Word not consumed by ack");
  a_cond_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_q == ST_WAIT && !output_mode_in && cond_mode_in == COND_EQ && sample != (cond_value_in & mask)) |-> !fire)
    else $error("Input taken before condition met");
endmodule : timed_serdes_io_port
